// ---- verilog/capture_pkg.sv ----
// Purpose : shared constants, register map and carriers for the capture sync and pixel output block
// Assumes : AXI4-Lite register access, 50 MHz core clock
// Notes   : Function
package capture_pkg;
   localparam int          DATA_W        = 8;
   localparam int          AXI_AW        = 8;
   localparam logic [7:0]  ADDR_CTRL     = 8'h00;
   localparam logic [7:0]  ADDR_CLAMP    = 8'h04;
   localparam logic [7:0]  ADDR_SYNCOUT  = 8'h08;
   localparam logic [7:0]  ADDR_STATUS   = 8'h0c;
   // control register field positions
   localparam int          B_HS_POL      = 7;
   localparam int          B_EXT_CLAMP   = 0;
   localparam int          B_CLAMP_POL   = 1;
   localparam int          B_HOLD_POL    = 2;
   localparam int          B_EXT_CLK     = 3;
   localparam int          B_DUAL        = 4;
   localparam int          B_PAR         = 5;
   localparam int          B_OUT_POL     = 6;
   localparam int          B_SLICE_SEL   = 8;
   localparam logic [31:0] CTRL_RESET    = 32'h0000_0004;
   localparam logic [7:0]  CLAMP_DLY_RST = 8'h04;
   localparam logic [7:0]  CLAMP_DUR_RST = 8'h04;
   localparam logic [7:0]  SYNC_WID_RST  = 8'h08;
   localparam logic [1:0]  RESP_OKAY     = 2'b00;
   localparam logic [1:0]  RESP_SLVERR   = 2'b10;

   typedef struct packed {
      logic [DATA_W-1:0] red;
      logic [DATA_W-1:0] green;
      logic [DATA_W-1:0] blue;
   } pixel_s;

   typedef struct packed {
      pixel_s port_a;
      pixel_s port_b;
   } pixel_out_s;
endpackage : capture_pkg

// ---- verilog/capture_sync_out.sv ----
// Purpose : capture-side sync handling, clamp timing and pixel output formatting
// Assumes : pixel clock and sync inputs are sampled by CORE_CLK_IN through 3-stage synchronisers
// Notes   : pixel, sync and data clock outputs change five core cycles after the pixel clock input edge
//
// Implementation choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
module capture_sync_out
   import capture_pkg::*;
(
   input  wire logic                CORE_CLK_IN,
   input  wire logic                RST_B_IN,
   // axi4-lite slave
   input  wire logic [AXI_AW-1:0]   S_AXI_AWADDR_IN,
   input  wire logic                S_AXI_AWVALID_IN,
   output logic                     S_AXI_AWREADY_OUT,
   input  wire logic [31:0]         S_AXI_WDATA_IN,
   input  wire logic [3:0]          S_AXI_WSTRB_IN,
   input  wire logic                S_AXI_WVALID_IN,
   output logic                     S_AXI_WREADY_OUT,
   output logic [1:0]               S_AXI_BRESP_OUT,
   output logic                     S_AXI_BVALID_OUT,
   input  wire logic                S_AXI_BREADY_IN,
   input  wire logic [AXI_AW-1:0]   S_AXI_ARADDR_IN,
   input  wire logic                S_AXI_ARVALID_IN,
   output logic                     S_AXI_ARREADY_OUT,
   output logic [31:0]              S_AXI_RDATA_OUT,
   output logic [1:0]               S_AXI_RRESP_OUT,
   output logic                     S_AXI_RVALID_OUT,
   input  wire logic                S_AXI_RREADY_IN,
   // capture side
   input  wire logic                LINE_SYNC_IN,
   input  wire logic                CLAMP_IN,
   input  wire logic                CLOCK_HOLD_IN,
   input  wire logic                GEN_PIXEL_CLOCK_IN,
   input  wire logic                EXTERNAL_PIXEL_CLOCK_IN,
   input  wire logic                SAMPLE_CLOCK_INVERT_IN,
   input  wire logic                GREEN_SYNC_IN,
   input  wire logic                ACTIVITY_DETECT_IN,
   input  wire capture_pkg::pixel_s SAMPLE_IN,
   output logic                     CLAMP_ACTIVE_OUT,
   output logic                     CLOCK_HOLD_OUT,
   output capture_pkg::pixel_out_s  PIXEL_OUT,
   output logic                     PORT_A_OE_B_OUT,
   output logic                     PORT_B_OE_B_OUT,
   output logic                     OUTPUT_DATA_CLOCK_OUT,
   output logic                     OUTPUT_DATA_CLOCK_B_OUT,
   output logic                     LINE_SYNC_OUT,
   output logic                     GREEN_SYNC_SLICER_OUT,
   output logic                     ACTIVITY_DETECT_OUT
);
   import capture_pkg::*;

   // ---------------------------------------------------------------
   // register file
   // ---------------------------------------------------------------
   logic [31:0] ctrl_r;
   logic [7:0]  clamp_dly_r, clamp_dur_r, sync_wid_r;
   logic        aw_hold_r, w_hold_r;
   logic [AXI_AW-1:0] aw_addr_r;
   logic [31:0] w_data_r;
   logic [3:0]  w_strb_r;
   logic        bvalid_r, rvalid_r;
   logic [1:0]  bresp_r, rresp_r;
   logic [31:0] rdata_r;

   // control fields
   wire hs_pol      = ctrl_r[B_HS_POL];
   wire ext_clamp   = ctrl_r[B_EXT_CLAMP];
   wire clamp_pol   = ctrl_r[B_CLAMP_POL];
   wire hold_pol    = ctrl_r[B_HOLD_POL];
   wire ext_clk     = ctrl_r[B_EXT_CLK];
   wire dual_port   = ctrl_r[B_DUAL];
   wire par_sel     = ctrl_r[B_PAR];
   wire out_pol     = ctrl_r[B_OUT_POL];
   wire slice_sel   = ctrl_r[B_SLICE_SEL];

   // write happens once both address and data are held
   wire do_write = aw_hold_r && w_hold_r && !bvalid_r;
   wire wr_ctrl  = do_write && (aw_addr_r[7:2] == ADDR_CTRL[7:2]);
   wire wr_clamp = do_write && (aw_addr_r[7:2] == ADDR_CLAMP[7:2]);
   wire wr_sync  = do_write && (aw_addr_r[7:2] == ADDR_SYNCOUT[7:2]);
   wire wr_stat  = do_write && (aw_addr_r[7:2] == ADDR_STATUS[7:2]);
   wire wr_hit   = wr_ctrl || wr_clamp || wr_sync || wr_stat;

   assign S_AXI_AWREADY_OUT = !aw_hold_r;
   assign S_AXI_WREADY_OUT  = !w_hold_r;
   assign S_AXI_BVALID_OUT  = bvalid_r;
   assign S_AXI_BRESP_OUT   = bresp_r;
   assign S_AXI_ARREADY_OUT = !rvalid_r;
   assign S_AXI_RVALID_OUT  = rvalid_r;
   assign S_AXI_RDATA_OUT   = rdata_r;
   assign S_AXI_RRESP_OUT   = rresp_r;

   // byte-lane merge
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++)
      begin
         if (st[i])
            res[i*8 +: 8] = nw[i*8 +: 8];
      end
      return res;
   endfunction : merge

   logic [31:0] clamp_word, sync_word, stat_word, ctrl_merged, clamp_merged, sync_merged;
   logic        hold_act, line_sync_act;
   assign clamp_word   = {16'h0000, clamp_dur_r, clamp_dly_r};
   assign sync_word    = {24'h000000, sync_wid_r};
   assign ctrl_merged  = merge(ctrl_r, w_data_r, w_strb_r);
   assign clamp_merged = merge(clamp_word, w_data_r, w_strb_r);
   assign sync_merged  = merge(sync_word, w_data_r, w_strb_r);

   // write channel capture and register update
   always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN)
   begin
      if (!RST_B_IN)
      begin
         aw_hold_r   <= 1'b0;
         w_hold_r    <= 1'b0;
         aw_addr_r   <= '0;
         w_data_r    <= '0;
         w_strb_r    <= '0;
         bvalid_r    <= 1'b0;
         bresp_r     <= RESP_OKAY;
         ctrl_r      <= CTRL_RESET;
         clamp_dly_r <= CLAMP_DLY_RST;
         clamp_dur_r <= CLAMP_DUR_RST;
         sync_wid_r  <= SYNC_WID_RST;
      end
      else
      begin
         if (S_AXI_AWVALID_IN && !aw_hold_r)
         begin
            aw_hold_r <= 1'b1;
            aw_addr_r <= S_AXI_AWADDR_IN;
         end
         if (S_AXI_WVALID_IN && !w_hold_r)
         begin
            w_hold_r <= 1'b1;
            w_data_r <= S_AXI_WDATA_IN;
            w_strb_r <= S_AXI_WSTRB_IN;
         end
         if (do_write)
         begin
            bvalid_r <= 1'b1;
            bresp_r  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
         end
         if (bvalid_r && S_AXI_BREADY_IN)
         begin
            bvalid_r  <= 1'b0;
            aw_hold_r <= 1'b0;
            w_hold_r  <= 1'b0;
         end
         if (wr_ctrl)
            ctrl_r <= ctrl_merged;
         if (wr_clamp)
         begin
            clamp_dly_r <= clamp_merged[7:0];
            clamp_dur_r <= clamp_merged[15:8];
         end
         if (wr_sync)
            sync_wid_r <= sync_merged[7:0];
      end
   end

   // read path with address decode
   logic [31:0] rd_mux;
   logic        rd_hit;
   always_comb
   begin
      rd_mux = 32'h0000_0000;
      rd_hit = 1'b1;
      if (S_AXI_ARADDR_IN[7:2] == ADDR_CTRL[7:2])
         rd_mux = ctrl_r;
      else if (S_AXI_ARADDR_IN[7:2] == ADDR_CLAMP[7:2])
         rd_mux = clamp_word;
      else if (S_AXI_ARADDR_IN[7:2] == ADDR_SYNCOUT[7:2])
         rd_mux = sync_word;
      else if (S_AXI_ARADDR_IN[7:2] == ADDR_STATUS[7:2])
         rd_mux = stat_word;
      else
         rd_hit = 1'b0;
   end

   always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN)
   begin
      if (!RST_B_IN)
      begin
         rvalid_r <= 1'b0;
         rdata_r  <= '0;
         rresp_r  <= RESP_OKAY;
      end
      else if (S_AXI_ARVALID_IN && !rvalid_r)
      begin
         rvalid_r <= 1'b1;
         rdata_r  <= rd_mux;
         rresp_r  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (rvalid_r && S_AXI_RREADY_IN)
         rvalid_r <= 1'b0;
   end

   // ---------------------------------------------------------------
   // input synchronisers (three stages, second and third must agree)
   // ---------------------------------------------------------------
   localparam int NSYNC = 8;
   logic [NSYNC-1:0] raw_in, s1_r, s2_r, s3_r, clean_r;
   assign raw_in = {ACTIVITY_DETECT_IN, GREEN_SYNC_IN, SAMPLE_CLOCK_INVERT_IN, EXTERNAL_PIXEL_CLOCK_IN,
                    GEN_PIXEL_CLOCK_IN, CLOCK_HOLD_IN, CLAMP_IN, LINE_SYNC_IN};

   genvar g;
   generate
      for (g = 0; g < NSYNC; g++)
      begin : g_sync
         always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN)
         begin
            if (!RST_B_IN)
            begin
               s1_r[g]    <= 1'b0;
               s2_r[g]    <= 1'b0;
               s3_r[g]    <= 1'b0;
               clean_r[g] <= 1'b0;
            end
            else
            begin
               s1_r[g] <= raw_in[g];
               s2_r[g] <= s1_r[g];
               s3_r[g] <= s2_r[g];
               if (s2_r[g] == s3_r[g])
                  clean_r[g] <= s3_r[g];
            end
         end
      end
   endgenerate

   wire hs_c     = clean_r[0];
   wire clamp_c  = clean_r[1];
   wire hold_c   = clean_r[2];
   wire gclk_c   = clean_r[3];
   wire eclk_c   = clean_r[4];
   wire inv_c    = clean_r[5];
   wire sog_c    = clean_r[6];
   wire act_c    = clean_r[7];

   // ---------------------------------------------------------------
   // sync edges, clamp, hold
   // ---------------------------------------------------------------
   logic hs_d_r, pclk_d_r;
   wire  hs_act    = hs_c ^ ~hs_pol;             // high while sync active
   wire  hs_act_d  = hs_d_r ^ ~hs_pol;
   wire  hs_lead   = hs_act && !hs_act_d;         // leading edge only
   wire  hs_trail  = !hs_act && hs_act_d;        // used only for clamp timing
   assign line_sync_act = hs_act;

   // hold level and clock source
   assign hold_act = hold_c ^ ~hold_pol;
   assign CLOCK_HOLD_OUT = hold_act;             // stops generator tracking
   wire  pclk_src  = ext_clk ? eclk_c : gclk_c;
   wire  pclk      = pclk_src ^ inv_c;
   wire  pclk_rise = pclk && !pclk_d_r;

   typedef enum logic [1:0] {CL_IDLE, CL_DELAY, CL_ON} clamp_e;
   clamp_e clamp_st_r;
   logic [7:0] clamp_cnt_r;
   logic       clamp_out_r;

   // internal clamp window counted in pixel clocks from trailing sync edge
   always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN)
   begin
      if (!RST_B_IN)
      begin
         hs_d_r      <= 1'b0;
         pclk_d_r    <= 1'b0;
         clamp_st_r  <= CL_IDLE;
         clamp_cnt_r <= '0;
         clamp_out_r <= 1'b0;
      end
      else
      begin
         hs_d_r   <= hs_c;
         pclk_d_r <= pclk;
         case (clamp_st_r)
            CL_DELAY:
               if (pclk_rise)
               begin
                  if (clamp_cnt_r == 8'h00)
                  begin
                     clamp_st_r  <= CL_ON;
                     clamp_cnt_r <= clamp_dur_r;
                  end
                  else
                     clamp_cnt_r <= clamp_cnt_r - 8'h01;
               end
            CL_ON:
               if (pclk_rise)
               begin
                  if (clamp_cnt_r == 8'h00)
                     clamp_st_r <= CL_IDLE;
                  else
                     clamp_cnt_r <= clamp_cnt_r - 8'h01;
               end
            default:
               clamp_st_r <= CL_IDLE;
         endcase
         if (hs_trail)                              // each trailing edge restarts
         begin
            clamp_st_r  <= CL_DELAY;
            clamp_cnt_r <= clamp_dly_r;
         end
         clamp_out_r <= ext_clamp ? (clamp_c ^ ~clamp_pol)
                                  : (clamp_st_r == CL_ON);
      end
   end
   assign CLAMP_ACTIVE_OUT = clamp_out_r;

   // ---------------------------------------------------------------
   // pixel output formatting
   // ---------------------------------------------------------------
   pixel_out_s pix_r;
   pixel_s     hold_a_r;
   logic       phase_b_r, dclk_r, lsync_r, slice_r, act_r, pend_r;
   logic [7:0] wid_cnt_r;
   wire        new_line = hs_lead || pend_r;   // lead kept until next pixel

   // pixel, sync and data clock outputs update on the same pixel edge; slicer and activity follow every core cycle
   always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN)
   begin
      if (!RST_B_IN)
      begin
         pix_r     <= '0;
         hold_a_r  <= '0;
         phase_b_r <= 1'b0;
         dclk_r    <= 1'b0;
         lsync_r   <= 1'b0;
         wid_cnt_r <= '0;
         slice_r   <= 1'b0;
         act_r     <= 1'b0;
         pend_r    <= 1'b0;
      end
      else
      begin
         act_r   <= act_c;
         slice_r <= slice_sel ? hs_c : sog_c;
         pend_r  <= new_line && !pclk_rise;
         if (!dual_port)
            dclk_r <= pclk;                                    // pixel rate
         if (pclk_rise)
         begin
            if (new_line)
               wid_cnt_r <= sync_wid_r;
            else if (wid_cnt_r != 8'h00)
               wid_cnt_r <= wid_cnt_r - 8'h01;
            lsync_r <= ((wid_cnt_r != 8'h00) || new_line) ^ out_pol;
            if (!dual_port)
            begin
               pix_r.port_a <= SAMPLE_IN;
               phase_b_r    <= 1'b0;
            end
            else
            begin
               dclk_r <= ~dclk_r;                                // half rate
               if (new_line || !phase_b_r)
               begin
                  phase_b_r <= 1'b1;
                  hold_a_r  <= SAMPLE_IN;
                  if (!par_sel)
                     pix_r.port_a <= SAMPLE_IN;
               end
               else
               begin
                  phase_b_r <= 1'b0;
                  pix_r.port_b <= SAMPLE_IN;
                  if (par_sel)
                     pix_r.port_a <= hold_a_r;
               end
            end
         end
      end
   end

   assign PIXEL_OUT               = pix_r;
   assign OUTPUT_DATA_CLOCK_OUT   = dclk_r;
   assign OUTPUT_DATA_CLOCK_B_OUT = ~dclk_r;
   assign LINE_SYNC_OUT           = lsync_r;
   assign GREEN_SYNC_SLICER_OUT   = slice_r;
   assign ACTIVITY_DETECT_OUT     = act_r;
   assign PORT_A_OE_B_OUT         = !act_r;
   assign PORT_B_OE_B_OUT         = !(act_r && dual_port);
   assign stat_word = {24'h000000, act_r, hold_act, clamp_out_r, phase_b_r, dclk_r, lsync_r, line_sync_act, hs_c};
endmodule : capture_sync_out

// ---- verif/capture_props.sv ----
// Purpose: port-level checks of capture_sync_out
// Assumes: one core clock domain, async low reset
// Notes:   bound to the design after the module
`timescale 1ns/1ps
module capture_props
   import capture_pkg::*;
(
   input wire logic                    CORE_CLK_IN,
   input wire logic                    RST_B_IN,
   input wire logic [AXI_AW-1:0]       S_AXI_AWADDR_IN,
   input wire logic                    S_AXI_AWVALID_IN,
   input wire logic                    S_AXI_AWREADY_OUT,
   input wire logic [1:0]              S_AXI_BRESP_OUT,
   input wire logic                    S_AXI_BVALID_OUT,
   input wire logic                    S_AXI_BREADY_IN,
   input wire logic [AXI_AW-1:0]       S_AXI_ARADDR_IN,
   input wire logic                    S_AXI_ARVALID_IN,
   input wire logic                    S_AXI_ARREADY_OUT,
   input wire logic [31:0]             S_AXI_RDATA_OUT,
   input wire logic [1:0]              S_AXI_RRESP_OUT,
   input wire logic                    S_AXI_RVALID_OUT,
   input wire logic                    S_AXI_RREADY_IN,
   input wire capture_pkg::pixel_out_s PIXEL_OUT,
   input wire logic                    PORT_A_OE_B_OUT,
   input wire logic                    PORT_B_OE_B_OUT,
   input wire logic                    OUTPUT_DATA_CLOCK_OUT,
   input wire logic                    OUTPUT_DATA_CLOCK_B_OUT,
   input wire logic                    LINE_SYNC_OUT,
   input wire logic                    ACTIVITY_DETECT_OUT
);
   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking cb @(posedge CORE_CLK_IN);
   endclocking
   default disable iff (!RST_B_IN);
   // unmapped write address then its error answer
   sequence bad_aw;
      S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT && S_AXI_AWADDR_IN > 8'h0f;
   endsequence
   sequence err_b;
      S_AXI_BVALID_OUT && S_AXI_BRESP_OUT == RESP_SLVERR;
   endsequence
   chk_clk_pair:
      assert property (OUTPUT_DATA_CLOCK_B_OUT == !OUTPUT_DATA_CLOCK_OUT) else $error("data clock pair broken");
   chk_idle_release:
      assert property (!ACTIVITY_DETECT_OUT [*2] |-> PORT_A_OE_B_OUT && PORT_B_OE_B_OUT)
      else $error("ports driven while inactive");
   chk_data_edge:
      assert property ($changed(PIXEL_OUT) && ACTIVITY_DETECT_OUT && $past(ACTIVITY_DETECT_OUT)
         |-> $changed(OUTPUT_DATA_CLOCK_OUT)) else $error("data moved off a data clock edge");
   chk_sync_edge:
      assert property ($changed(LINE_SYNC_OUT) |-> $changed(OUTPUT_DATA_CLOCK_OUT))
      else $error("sync out moved off a data clock edge");
   chk_b_done:
      assert property (S_AXI_BVALID_OUT && S_AXI_BREADY_IN |=> !S_AXI_BVALID_OUT) else $error("bvalid stuck");
   chk_r_done:
      assert property (S_AXI_RVALID_OUT && S_AXI_RREADY_IN |=> !S_AXI_RVALID_OUT) else $error("rvalid stuck");
   chk_bad_read:
      assert property (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT && !S_AXI_RVALID_OUT && S_AXI_ARADDR_IN > 8'h0f
         |=> S_AXI_RVALID_OUT && S_AXI_RRESP_OUT == RESP_SLVERR && S_AXI_RDATA_OUT == 32'h0)
      else $error("unmapped read not refused");
   chk_bad_write:
      assert property (bad_aw |-> ##[1:4] err_b) else $error("unmapped write not refused");
   chk_aw_block:
      assert property (S_AXI_BVALID_OUT |-> !S_AXI_AWREADY_OUT) else $error("address taken during response");
endmodule : capture_props
bind capture_sync_out capture_props u_props (.*);

// ---- verif/pixel_sink.sv ----
// Purpose: downstream panel logic latching pixels on data clock moves
// Assumes: data settles in the cycle the data clock toggles
// Notes:   a released port reads as the inverse of its last value
`timescale 1ns/1ps
module pixel_sink
   import capture_pkg::*;
(
   input wire logic                    clk_in,
   input wire logic                    rst_b_in,
   input wire logic                    data_clock_in,
   input wire logic                    oe_a_b_in,
   input wire logic                    oe_b_b_in,
   input wire capture_pkg::pixel_out_s pixel_in,
   output capture_pkg::pixel_out_s     seen_out,
   output logic [15:0]                 rises_out
);
   logic dck_r;
   // ----------------------------------------
   // capture on either data clock edge
   // ----------------------------------------
   always_ff @(posedge clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         dck_r     <= 1'h0;
         rises_out <= 16'h0;
         seen_out  <= '0;
      end
      else
      begin
         dck_r <= data_clock_in;
         if (data_clock_in != dck_r)
         begin
            seen_out.port_a <= oe_a_b_in ? ~seen_out.port_a : pixel_in.port_a;
            seen_out.port_b <= oe_b_b_in ? ~seen_out.port_b : pixel_in.port_b;
         end
         if (data_clock_in && !dck_r)
            rises_out <= rises_out + 16'h1;
      end
   end
endmodule : pixel_sink

// ---- verif/tb.sv ----
// Purpose: self-checking bench for capture_sync_out
// Assumes: bench makes pixel clock and sync, 160 ns per pixel
// Notes:   sample invert is raised only after the last line
`timescale 1ns/1ps
module tb;
   import capture_pkg::*;
   typedef struct {logic [31:0] ctrl; logic ext; logic hs_idle; logic dual; logic par; logic [15:0] rises;} row_s;
   logic CORE_CLK_IN, RST_B_IN, S_AXI_AWVALID_IN, S_AXI_WVALID_IN, S_AXI_BREADY_IN;
   logic S_AXI_ARVALID_IN, S_AXI_RREADY_IN, S_AXI_AWREADY_OUT, S_AXI_WREADY_OUT;
   logic S_AXI_BVALID_OUT, S_AXI_ARREADY_OUT, S_AXI_RVALID_OUT;
   logic [7:0] S_AXI_AWADDR_IN, S_AXI_ARADDR_IN;
   logic [31:0] S_AXI_WDATA_IN, S_AXI_RDATA_OUT, rd;
   logic [3:0] S_AXI_WSTRB_IN;
   logic [1:0] S_AXI_BRESP_OUT, S_AXI_RRESP_OUT, rsp;
   logic LINE_SYNC_IN, CLAMP_IN, CLOCK_HOLD_IN, GEN_PIXEL_CLOCK_IN, EXTERNAL_PIXEL_CLOCK_IN;
   logic SAMPLE_CLOCK_INVERT_IN, GREEN_SYNC_IN, ACTIVITY_DETECT_IN, CLAMP_ACTIVE_OUT, CLOCK_HOLD_OUT;
   logic PORT_A_OE_B_OUT, PORT_B_OE_B_OUT, OUTPUT_DATA_CLOCK_OUT, OUTPUT_DATA_CLOCK_B_OUT;
   logic LINE_SYNC_OUT, GREEN_SYNC_SLICER_OUT, ACTIVITY_DETECT_OUT;
   pixel_s SAMPLE_IN;
   pixel_out_s PIXEL_OUT, seen;
   logic [15:0] rises, r0;
   row_s rows [5];
   int n_errors, cmp_count, clamp_px, i;
   capture_sync_out dut (.*);
   pixel_sink sink (.clk_in(CORE_CLK_IN), .rst_b_in(RST_B_IN), .data_clock_in(OUTPUT_DATA_CLOCK_OUT),
      .oe_a_b_in(PORT_A_OE_B_OUT), .oe_b_b_in(PORT_B_OE_B_OUT), .pixel_in(PIXEL_OUT), .seen_out(seen),
      .rises_out(rises));
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   initial
   begin
      CORE_CLK_IN = 1'h0;
      forever #10 CORE_CLK_IN = ~CORE_CLK_IN;
   end
   task automatic idle(input int n);
      repeat (n) @(posedge CORE_CLK_IN);
   endtask : idle
   task automatic chk(input logic [47:0] got, input logic [47:0] exp, input string what);
      cmp_count++;
      if (got !== exp)
      begin
         n_errors++;
         $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk
   task automatic stop_test;
      $display("comparisons %0d, mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : stop_test
   task automatic no_answer(input int n);
      if (n == 50)
      begin
         n_errors++;
         $display("mismatch at %0t: bus answer timed out", $time);
         stop_test();
      end
   endtask : no_answer
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      int n;
      S_AXI_AWADDR_IN <= a;
      S_AXI_WDATA_IN <= d;
      S_AXI_AWVALID_IN <= 1'h1;
      S_AXI_WVALID_IN <= 1'h1;
      S_AXI_BREADY_IN <= 1'h1;
      for (n = 0; n < 50 && !S_AXI_BVALID_OUT; n++)
      begin
         @(posedge CORE_CLK_IN);
         if (S_AXI_AWREADY_OUT)
            S_AXI_AWVALID_IN <= 1'h0;
         if (S_AXI_WREADY_OUT)
            S_AXI_WVALID_IN <= 1'h0;
      end
      r = S_AXI_BRESP_OUT;
      S_AXI_BREADY_IN <= 1'h0;
      no_answer(n);
      idle(1);
   endtask : axi_wr
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      S_AXI_ARADDR_IN <= a;
      S_AXI_ARVALID_IN <= 1'h1;
      S_AXI_RREADY_IN <= 1'h1;
      for (n = 0; n < 50 && !S_AXI_RVALID_OUT; n++)
      begin
         @(posedge CORE_CLK_IN);
         if (S_AXI_ARREADY_OUT)
            S_AXI_ARVALID_IN <= 1'h0;
      end
      d = S_AXI_RDATA_OUT;
      r = S_AXI_RRESP_OUT;
      S_AXI_RREADY_IN <= 1'h0;
      no_answer(n);
      idle(1);
   endtask : axi_rd
   function automatic pixel_s pix(input int k);
      pixel_s p;
      p.red = 8'h10 + k[7:0];
      p.green = 8'h20 + k[7:0];
      p.blue = 8'h30 + k[7:0];
      return p;
   endfunction : pix
   // sync pulse: leading edge, then trailing edge
   task automatic line_start;
      LINE_SYNC_IN <= ~LINE_SYNC_IN;
      idle(8);
      LINE_SYNC_IN <= ~LINE_SYNC_IN;
      idle(8);
   endtask : line_start
   task automatic pixels(input int first, input int cnt, input logic ext);
      int k;
      for (k = first; k < first + cnt; k++)
      begin
         idle(2);
         SAMPLE_IN <= pix(k);
         idle(2);
         if (ext)
            EXTERNAL_PIXEL_CLOCK_IN <= 1'h1;
         else
            GEN_PIXEL_CLOCK_IN <= 1'h1;
         idle(4);
         EXTERNAL_PIXEL_CLOCK_IN <= 1'h0;
         GEN_PIXEL_CLOCK_IN <= 1'h0;
         if (CLAMP_ACTIVE_OUT === 1'h1)
            clamp_px++;
      end
      idle(12);
   endtask : pixels
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial
   begin
      rows[0] = '{32'h84, 1'h0, 1'h0, 1'h0, 1'h0, 16'h4};
      rows[1] = '{32'h94, 1'h0, 1'h0, 1'h1, 1'h0, 16'h2};
      rows[2] = '{32'hb4, 1'h0, 1'h0, 1'h1, 1'h1, 16'h2};
      rows[3] = '{32'h14, 1'h0, 1'h1, 1'h1, 1'h0, 16'h2};
      rows[4] = '{32'h8c, 1'h1, 1'h0, 1'h0, 1'h0, 16'h4};
      {RST_B_IN, S_AXI_AWVALID_IN, S_AXI_WVALID_IN, S_AXI_BREADY_IN, S_AXI_ARVALID_IN, S_AXI_RREADY_IN} = '0;
      {S_AXI_AWADDR_IN, S_AXI_ARADDR_IN, S_AXI_WDATA_IN, SAMPLE_IN} = '0;
      S_AXI_WSTRB_IN = 4'hf;
      {LINE_SYNC_IN, CLAMP_IN, GEN_PIXEL_CLOCK_IN, EXTERNAL_PIXEL_CLOCK_IN, GREEN_SYNC_IN} = '0;
      CLOCK_HOLD_IN = 1'h0;
      SAMPLE_CLOCK_INVERT_IN = 1'h0;
      ACTIVITY_DETECT_IN = 1'h1;
      idle(20);
      RST_B_IN <= 1'h1;
      idle(12);
      chk(OUTPUT_DATA_CLOCK_B_OUT, 1'h1, "data clock b at reset");
      chk(CLOCK_HOLD_OUT, 1'h0, "hold tied low");
      axi_rd(ADDR_CTRL, rd, rsp);
      chk(rd, CTRL_RESET, "control reset");
      axi_rd(ADDR_CLAMP, rd, rsp);
      chk(rd[15:0], {CLAMP_DUR_RST, CLAMP_DLY_RST}, "clamp reset");
      axi_rd(ADDR_SYNCOUT, rd, rsp);
      chk(rd[7:0], SYNC_WID_RST, "sync width reset");
      axi_rd(8'h40, rd, rsp);
      chk({rsp, rd}, {RESP_SLVERR, 32'h0}, "unmapped read");
      axi_wr(8'h40, 32'h1, rsp);
      chk(rsp, RESP_SLVERR, "unmapped write");
      $display("reset and register test done");
      for (i = 0; i < 5; i++)
      begin
         LINE_SYNC_IN <= rows[i].hs_idle;
         axi_wr(ADDR_CTRL, rows[i].ctrl, rsp);
         chk(rsp, RESP_OKAY, "control write");
         idle(12);
         r0 = rises;
         line_start();
         pixels(0, 3, rows[i].ext);
         chk(seen.port_a, (rows[i].dual && rows[i].par) ? pix(0) : pix(2), "port a 3rd");
         if (rows[i].dual)
            chk(seen.port_b, pix(1), "port b 3rd");
         chk(LINE_SYNC_OUT, 1'h1, "sync out high");
         pixels(3, 1, rows[i].ext);
         chk(seen.port_a, rows[i].dual ? pix(2) : pix(3), "port a 4th");
         if (rows[i].dual)
            chk(seen.port_b, pix(3), "port b 4th");
         chk(PORT_B_OE_B_OUT, !rows[i].dual, "port b enable");
         chk(rises - r0, rows[i].rises, "data clock rises");
         $display("mode row %0d done", i);
      end
      CLAMP_IN <= 1'h1;
      axi_wr(ADDR_CTRL, 32'h84, rsp);
      clamp_px = 0;
      line_start();
      pixels(0, 12, 1'h0);
      chk(clamp_px, CLAMP_DUR_RST + 1, "internal clamp length");
      chk(LINE_SYNC_OUT, 1'h0, "sync out ended");
      axi_wr(ADDR_CTRL, 32'h87, rsp);
      idle(12);
      chk(CLAMP_ACTIVE_OUT, 1'h1, "external clamp high");
      axi_wr(ADDR_CTRL, 32'h85, rsp);
      idle(12);
      chk(CLAMP_ACTIVE_OUT, 1'h0, "external clamp low sense");
      CLAMP_IN <= 1'h0;
      idle(12);
      chk(CLAMP_ACTIVE_OUT, 1'h1, "external clamp low active");
      $display("clamp test done");
      CLOCK_HOLD_IN <= 1'h1;
      idle(12);
      chk(CLOCK_HOLD_OUT, 1'h1, "hold asserted");
      axi_wr(ADDR_CTRL, 32'h80, rsp);
      idle(12);
      chk(CLOCK_HOLD_OUT, 1'h0, "hold tied high");
      $display("hold test done");
      axi_wr(ADDR_CTRL, 32'h184, rsp);
      LINE_SYNC_IN <= 1'h1;
      idle(12);
      chk(GREEN_SYNC_SLICER_OUT, 1'h1, "raw sync high");
      LINE_SYNC_IN <= 1'h0;
      GREEN_SYNC_IN <= 1'h1;
      idle(12);
      chk(GREEN_SYNC_SLICER_OUT, 1'h0, "raw sync low");
      axi_wr(ADDR_CTRL, 32'h84, rsp);
      idle(12);
      chk(GREEN_SYNC_SLICER_OUT, 1'h1, "green slicer");
      $display("slicer test done");
      ACTIVITY_DETECT_IN <= 1'h0;
      SAMPLE_CLOCK_INVERT_IN <= 1'h1;
      idle(12);
      chk(OUTPUT_DATA_CLOCK_OUT, 1'h1, "inverted clock");
      chk({ACTIVITY_DETECT_OUT, PORT_A_OE_B_OUT, PORT_B_OE_B_OUT}, 3'h3, "inactive release");
      $display("activity test done");
      stop_test();
   end
endmodule : tb
